// ===== include/gauge_ctl_pkg.sv
// constants and carriers for the control subcommand unit
package gauge_ctl_pkg;
  // subcommand codes
  localparam logic [15:0] SC_STATUS = 16'h0000;
  localparam logic [15:0] SC_DEV_TYPE = 16'h0001;
  localparam logic [15:0] SC_FW_REV = 16'h0002;
  localparam logic [15:0] SC_HW_REV = 16'h0003;
  localparam logic [15:0] SC_RESET_COUNT = 16'h0005;
  localparam logic [15:0] SC_LAST_SUB = 16'h0007;
  localparam logic [15:0] SC_CHEMISTRY_ID_QUERY = 16'h0008;
  localparam logic [15:0] SC_BOARD_CAL = 16'h0009;
  localparam logic [15:0] SC_CNT_CAL = 16'h000a;
  localparam logic [15:0] SC_CNT_STORE = 16'h000b;
  localparam logic [15:0] SC_FLASH_REV = 16'h000c;
  localparam logic [15:0] SC_ARM_DEEP = 16'h0010;
  localparam logic [15:0] SC_CHEM_SUM = 16'h0017;
  localparam logic [15:0] SC_CURRENT = 16'h0018;
  localparam logic [15:0] SC_LOCK = 16'h0020;
  localparam logic [15:0] SC_GAUGE_START = 16'h0021;
  localparam logic [15:0] SC_CAL_TOGGLE = 16'h002d;
  localparam logic [15:0] SC_FULL_RESET = 16'h0041;
  localparam logic [15:0] SC_CAL_EXIT = 16'h0080;
  localparam logic [15:0] SC_CAL_ENTER = 16'h0081;
  localparam logic [15:0] SC_CAL_OFFSET = 16'h0082;
  localparam logic [15:0] LAST_SUB_LIMIT = 16'h0020;
  // command pair codes on the serial link
  localparam logic [7:0] CMD_CTL_LO = 8'h00;
  localparam logic [7:0] CMD_CTL_HI = 8'h01;
  // status word field positions
  localparam int BIT_FULL_LOCKED = 14;
  localparam int BIT_LOCKED = 13;
  localparam int BIT_CAL_MODE = 12;
  localparam int BIT_CNT_CAL = 11;
  localparam int BIT_BOARD_CAL = 10;
  localparam int BIT_FLASH_SUM = 9;
  localparam int BIT_DEEP_DOZE = 5;
  localparam int BIT_SLEEP = 4;
  localparam int BIT_CONST_POWER = 3;
  localparam int BIT_RES_OFF = 2;
  localparam int BIT_VOLT_GOOD = 1;
  localparam int BIT_CAP_ON = 0;
  localparam int BIT_LEARN_GAUGE = 2;
  localparam logic [15:0] CHKSUM_MASK = 16'h7fff;
  localparam logic [15:0] CHKSUM_FAIL = 16'h8000;
  // wake clock stretch, least 6 ms
  localparam longint WAKE_STRETCH_NS = 64'd6000000;
  localparam longint CLK_PERIOD_NS = 64'd5;
  localparam int WAKE_STRETCH_CYC = int'((WAKE_STRETCH_NS + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS);

  // one byte transaction from the serial engine
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] cmd;
    logic [7:0] data;
  } bus_xfer_s;

  // gauge side status fed into the word
  typedef struct packed {
    logic full_locked;
    logic flash_sum_ok;
    logic sleep;
    logic const_power;
    logic res_off;
    logic volt_bad;
  } gauge_state_s;

  // one-cycle action strobes toward the gauge core
  typedef struct packed {
    logic board_cal_start;
    logic cnt_cal_start;
    logic cnt_store;
    logic chem_sum_start;
    logic full_reset;
  } action_s;
endpackage

// ===== hw/ctl_word_pair.sv
// two-byte control word holding register with byte read and write ports
`timescale 1ns/1ps
module ctl_word_pair (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [7:0] wr_byte,
  input wire logic load,
  input wire logic [15:0] load_word,
  input wire logic rd_sel_hi,
  output logic [15:0] word,
  output logic [7:0] rd_byte
);
  logic [15:0] word_reg;

  // ----------------------------------------
  // storage; a load from the decoder wins over a host byte
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      word_reg <= 16'h0000;
    end else if (load) begin
      word_reg <= load_word;
    end else begin
      if (wr_lo) begin
        word_reg[7:0] <= wr_byte;
      end
      if (wr_hi) begin
        word_reg[15:8] <= wr_byte;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_byte <= 8'h00;
    end else begin
      rd_byte <= rd_sel_hi ? word_reg[15:8] : word_reg[7:0];
    end
  end

  assign word = word_reg;
endmodule

// ===== hw/gauge_control_subcommand_unit.sv
// control subcommand decoder and status word of the gauge
`timescale 1ns/1ps
// How it works
// - host writes a two-byte subcommand to the control pair; decoder picks the function
// - code 0000 returns the status word; allowed while locked
// - high byte: full-locked 6, locked 5, cal 4, counter cal 3, board cal 2, sum ok 1
// - low byte: deep doze 5, sleep 4, const power 3, res off 2, volt ok 1, cap on 0
// - code 0001 returns a fixed device type; allowed while locked
// - codes 0002 and 0003 return firmware and hardware revisions; allowed while locked
// - code 0005 returns reset count; refused while locked
// - code 0007 returns previous subcommand, always below 0020
// - codes 0008 and 000c return chemistry id and flash revision; allowed locked
// - code 0009 starts board calibration; board busy flag set throughout
// - code 000a starts counter calibration; counter busy flag set throughout
// - code 000b stores counter offset persistently
// - code 0010 sets deep doze flag; deep sleep entered after sleep seen
// - first i2c message in deep sleep is stretched 6 to 8 ms
// - first single-wire message in deep sleep is dropped; host repeats it
// - any traffic in deep sleep returns to sleep and clears deep doze
// - code 0017 checks 15-bit chemistry sum; top bit set on mismatch
// - code 0018 returns instantaneous current; allowed while locked
// - code 0020 moves open state into locked state
// - code 0021, open only, starts gauging, sets learn bit 2, volt ok, cap on
// - code 0041 does a full reset, only while open
// - 002d toggles, 0081 enters, 0080 exits cal mode; flag follows
// - code 0082 reports counter offset in cal mode; refused while locked
// - command word moves as two byte transactions at 00 and 01
module gauge_control_subcommand_unit #(
  parameter logic [15:0] DEVICE_TYPE = 16'h1234, // arbitrary value
  parameter logic [15:0] FW_REV = 16'h0100,
  parameter logic [15:0] HW_REV = 16'h0001,
  parameter logic [15:0] FLASH_REV = 16'h0001,
  parameter logic [15:0] CHEMISTRY_ID_QUERY = 16'h0100,
  parameter int STRETCH_CYC = gauge_ctl_pkg::WAKE_STRETCH_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire gauge_ctl_pkg::bus_xfer_s xfer,
  input wire logic xfer_is_i2c,
  input wire logic msg_start,
  input wire gauge_ctl_pkg::gauge_state_s gstate,
  input wire logic [15:0] reset_count,
  input wire logic [15:0] current_now,
  input wire logic [15:0] cnt_offset,
  input wire logic board_cal_done,
  input wire logic cnt_cal_done,
  input wire logic chem_sum_done,
  input wire logic [15:0] chem_sum_raw,
  input wire logic [15:0] chem_sum_stored,
  output logic [7:0] rd_byte,
  output logic scl_stretch,
  output logic drop_msg,
  output logic osc_off,
  output logic [7:0] learn_progress,
  output gauge_ctl_pkg::action_s act,
  output logic [15:0] status_word
);
  typedef enum logic [1:0] {PWR_AWAKE, PWR_ARMED, PWR_DEEP, PWR_WAKING} pwr_e;

  logic locked_reg, cal_reg, cnt_busy_reg, board_busy_reg, doze_reg, volt_reg, cap_reg;
  logic sum_busy_reg, hi_seen_reg, cmd_go_reg;
  logic [15:0] last_sub_reg, cmd_word;
  logic [15:0] load_word;
  logic load;
  logic [7:0] learn_reg;
  logic [31:0] stretch_reg;
  pwr_e pwr_reg;
  gauge_ctl_pkg::action_s act_reg;
  logic ctl_wr_lo, ctl_wr_hi, traffic;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic allowed_locked(input logic [15:0] code);
    unique case (code)
      gauge_ctl_pkg::SC_STATUS, gauge_ctl_pkg::SC_DEV_TYPE, gauge_ctl_pkg::SC_FW_REV,
      gauge_ctl_pkg::SC_HW_REV, gauge_ctl_pkg::SC_CHEMISTRY_ID_QUERY, gauge_ctl_pkg::SC_FLASH_REV,
      gauge_ctl_pkg::SC_CHEM_SUM, gauge_ctl_pkg::SC_CURRENT: allowed_locked = 1'b1;
      default: allowed_locked = 1'b0;
    endcase
  endfunction

  function automatic logic is_code(input logic [15:0] code, input logic [15:0] ref_code);
    is_code = (code == ref_code);
  endfunction

  // ----------------------------------------
  // byte transactions on the control pair
  // ----------------------------------------
  // bytes land in the pair; a write to the high byte completes the subcommand
  assign ctl_wr_lo = xfer.valid && xfer.write && (xfer.cmd == gauge_ctl_pkg::CMD_CTL_LO);
  assign ctl_wr_hi = xfer.valid && xfer.write && (xfer.cmd == gauge_ctl_pkg::CMD_CTL_HI);
  assign traffic = msg_start;

  always_ff @(posedge clk) begin
    if (rst) begin
      hi_seen_reg <= 1'b0;
      cmd_go_reg <= 1'b0;
    end else begin
      hi_seen_reg <= ctl_wr_hi;
      cmd_go_reg <= hi_seen_reg;
    end
  end

  // one cycle after the high byte lands the word is whole
  logic go;
  logic permit;
  assign go = cmd_go_reg;
  assign permit = !locked_reg || allowed_locked(cmd_word);

  // ----------------------------------------
  // status word assembly
  // ----------------------------------------
  always_comb begin
    status_word = 16'h0000;
    status_word[gauge_ctl_pkg::BIT_FULL_LOCKED] = gstate.full_locked;
    status_word[gauge_ctl_pkg::BIT_LOCKED] = locked_reg;
    status_word[gauge_ctl_pkg::BIT_CAL_MODE] = cal_reg;
    status_word[gauge_ctl_pkg::BIT_CNT_CAL] = cnt_busy_reg;
    status_word[gauge_ctl_pkg::BIT_BOARD_CAL] = board_busy_reg;
    status_word[gauge_ctl_pkg::BIT_FLASH_SUM] = gstate.flash_sum_ok;
    status_word[gauge_ctl_pkg::BIT_DEEP_DOZE] = doze_reg;
    status_word[gauge_ctl_pkg::BIT_SLEEP] = gstate.sleep;
    status_word[gauge_ctl_pkg::BIT_CONST_POWER] = gstate.const_power;
    status_word[gauge_ctl_pkg::BIT_RES_OFF] = gstate.res_off;
    status_word[gauge_ctl_pkg::BIT_VOLT_GOOD] = volt_reg;
    status_word[gauge_ctl_pkg::BIT_CAP_ON] = cap_reg;
  end

  // ----------------------------------------
  // answer word selection
  // ----------------------------------------
  always_comb begin
    load = 1'b0;
    load_word = 16'h0000;
    if (go && permit) begin
      load = 1'b1;
      unique case (cmd_word)
        gauge_ctl_pkg::SC_STATUS: load_word = status_word;
        gauge_ctl_pkg::SC_DEV_TYPE: load_word = DEVICE_TYPE;
        gauge_ctl_pkg::SC_FW_REV: load_word = FW_REV;
        gauge_ctl_pkg::SC_HW_REV: load_word = HW_REV;
        gauge_ctl_pkg::SC_RESET_COUNT: load_word = reset_count;
        gauge_ctl_pkg::SC_LAST_SUB: load_word = last_sub_reg;
        gauge_ctl_pkg::SC_CHEMISTRY_ID_QUERY: load_word = CHEMISTRY_ID_QUERY;
        gauge_ctl_pkg::SC_FLASH_REV: load_word = FLASH_REV;
        gauge_ctl_pkg::SC_CURRENT: load_word = current_now;
        gauge_ctl_pkg::SC_CAL_OFFSET: begin
          load = cal_reg;
          load_word = cnt_offset;
        end
        default: load = 1'b0;
      endcase
    end
    // checksum verdict lands when the core finishes
    if (chem_sum_done && sum_busy_reg) begin
      load = 1'b1;
      load_word = ((chem_sum_raw & gauge_ctl_pkg::CHKSUM_MASK) == (chem_sum_stored & gauge_ctl_pkg::CHKSUM_MASK))
        ? (chem_sum_raw & gauge_ctl_pkg::CHKSUM_MASK)
        : ((chem_sum_raw & gauge_ctl_pkg::CHKSUM_MASK) | gauge_ctl_pkg::CHKSUM_FAIL);
    end
  end

  ctl_word_pair u_pair (
    .clk(clk),
    .rst(rst),
    .wr_lo(ctl_wr_lo),
    .wr_hi(ctl_wr_hi),
    .wr_byte(xfer.data),
    .load(load),
    .load_word(load_word),
    .rd_sel_hi(xfer.cmd == gauge_ctl_pkg::CMD_CTL_HI),
    .word(cmd_word),
    .rd_byte(rd_byte)
  );

  // ----------------------------------------
  // previous subcommand, kept below the limit
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      last_sub_reg <= 16'h0000;
    end else if (go && permit && cmd_word < gauge_ctl_pkg::LAST_SUB_LIMIT) begin
      last_sub_reg <= cmd_word;
    end
  end

  // ----------------------------------------
  // access state and calibration mode
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      locked_reg <= 1'b0;
    end else if (go && !locked_reg && is_code(cmd_word, gauge_ctl_pkg::SC_LOCK)) begin
      locked_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cal_reg <= 1'b0;
    end else if (go && permit) begin
      if (is_code(cmd_word, gauge_ctl_pkg::SC_CAL_TOGGLE)) begin
        cal_reg <= !cal_reg;
      end else if (is_code(cmd_word, gauge_ctl_pkg::SC_CAL_ENTER)) begin
        cal_reg <= 1'b1;
      end else if (is_code(cmd_word, gauge_ctl_pkg::SC_CAL_EXIT)) begin
        cal_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // calibration and checksum busy flags; a start beats a same-cycle done
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      board_busy_reg <= 1'b0;
      cnt_busy_reg <= 1'b0;
      sum_busy_reg <= 1'b0;
    end else begin
      if (go && permit && is_code(cmd_word, gauge_ctl_pkg::SC_BOARD_CAL)) begin
        board_busy_reg <= 1'b1;
      end else if (board_cal_done) begin
        board_busy_reg <= 1'b0;
      end
      if (go && permit && is_code(cmd_word, gauge_ctl_pkg::SC_CNT_CAL)) begin
        cnt_busy_reg <= 1'b1;
      end else if (cnt_cal_done) begin
        cnt_busy_reg <= 1'b0;
      end
      if (go && permit && is_code(cmd_word, gauge_ctl_pkg::SC_CHEM_SUM)) begin
        sum_busy_reg <= 1'b1;
      end else if (chem_sum_done) begin
        sum_busy_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // action strobes toward the gauge core
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      act_reg <= '0;
    end else begin
      act_reg.board_cal_start <= go && permit && is_code(cmd_word, gauge_ctl_pkg::SC_BOARD_CAL);
      act_reg.cnt_cal_start <= go && permit && is_code(cmd_word, gauge_ctl_pkg::SC_CNT_CAL);
      act_reg.cnt_store <= go && permit && is_code(cmd_word, gauge_ctl_pkg::SC_CNT_STORE);
      act_reg.chem_sum_start <= go && permit && is_code(cmd_word, gauge_ctl_pkg::SC_CHEM_SUM);
      act_reg.full_reset <= go && !locked_reg && is_code(cmd_word, gauge_ctl_pkg::SC_FULL_RESET);
    end
  end
  assign act = act_reg;

  // ----------------------------------------
  // gauging enable; capacity update is sticky by design
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      volt_reg <= 1'b0;
      cap_reg <= 1'b0;
      learn_reg <= 8'h00;
    end else begin
      if (go && !locked_reg && is_code(cmd_word, gauge_ctl_pkg::SC_GAUGE_START)) begin
        volt_reg <= 1'b1;
        cap_reg <= 1'b1;
        learn_reg[gauge_ctl_pkg::BIT_LEARN_GAUGE] <= 1'b1;
      end else if (gstate.volt_bad) begin
        volt_reg <= 1'b0;
      end
    end
  end
  assign learn_progress = learn_reg;

  // ----------------------------------------
  // deep sleep arming and wake
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      pwr_reg <= PWR_AWAKE;
      doze_reg <= 1'b0;
      stretch_reg <= '0;
    end else begin
      unique case (pwr_reg)
        PWR_AWAKE: begin
          if (go && permit && is_code(cmd_word, gauge_ctl_pkg::SC_ARM_DEEP)) begin
            doze_reg <= 1'b1;
            pwr_reg <= PWR_ARMED;
          end
        end
        PWR_ARMED: begin
          if (traffic) begin
            doze_reg <= 1'b0;
            pwr_reg <= PWR_AWAKE;
          end else if (gstate.sleep) begin
            pwr_reg <= PWR_DEEP;
          end
        end
        PWR_DEEP: begin
          if (traffic) begin
            doze_reg <= 1'b0;
            stretch_reg <= 32'(STRETCH_CYC);
            pwr_reg <= xfer_is_i2c ? PWR_WAKING : PWR_AWAKE;
          end
        end
        PWR_WAKING: begin
          // oscillator restart; scl is held low the whole count
          if (stretch_reg <= 32'd1) begin
            pwr_reg <= PWR_AWAKE;
          end
          stretch_reg <= stretch_reg - 32'd1;
        end
      endcase
    end
  end

  assign osc_off = (pwr_reg == PWR_DEEP);
  assign scl_stretch = (pwr_reg == PWR_WAKING) || (osc_off && traffic && xfer_is_i2c);
  // single-wire host must repeat the dropped message
  assign drop_msg = osc_off && traffic && !xfer_is_i2c;
endmodule

// ===== verif/gauge_ctl_sva.sv
// concurrent checks on the control subcommand unit ports
`timescale 1ns/1ps
module gauge_ctl_sva #(
  parameter int STRETCH_CYC = 10
) (
  input wire logic clk,
  input wire logic rst,
  input wire gauge_ctl_pkg::bus_xfer_s xfer,
  input wire logic xfer_is_i2c,
  input wire logic msg_start,
  input wire gauge_ctl_pkg::gauge_state_s gstate,
  input wire logic board_cal_done,
  input wire logic cnt_cal_done,
  input wire logic scl_stretch,
  input wire logic drop_msg,
  input wire logic osc_off,
  input wire gauge_ctl_pkg::action_s act,
  input wire logic [15:0] status_word
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ----
  // helpers
  // ----
  int stretch_len;
  logic [5:0] hi_hist;
  always_ff @(posedge clk) begin
    if (rst || !scl_stretch) begin
      stretch_len <= 0;
    end else begin
      stretch_len <= stretch_len + 1;
    end
  end
  // strobes must trace back to a fresh command word
  always_ff @(posedge clk) begin
    if (rst) begin
      hi_hist <= '0;
    end else begin
      hi_hist <= {hi_hist[4:0], xfer.valid && xfer.write && xfer.cmd == gauge_ctl_pkg::CMD_CTL_HI};
    end
  end
  sequence s_board_up;
    ##[0:3] status_word[10];
  endsequence
  sequence s_cnt_up;
    ##[0:3] status_word[11];
  endsequence
  // ----
  // assertions
  // ----
  a_unused_bits_zero: assert property (status_word[15] == 1'b0 && status_word[8:6] == 3'b000)
    else $error("unused status bits set");
  a_high_flag_map: assert property ($stable(gstate) [*3] |-> status_word[14] == gstate.full_locked &&
    status_word[9] == gstate.flash_sum_ok)
    else $error("high status flags wrong");
  a_low_flag_map: assert property ($stable(gstate) [*3] |-> status_word[3:2] == {gstate.const_power, gstate.res_off})
    else $error("low status flags wrong");
  a_board_flag_up: assert property (act.board_cal_start |-> s_board_up)
    else $error("board busy flag missing");
  a_cnt_flag_up: assert property (act.cnt_cal_start |-> s_cnt_up)
    else $error("counter busy flag missing");
  a_board_busy_hold: assert property (status_word[10] && !board_cal_done |=> status_word[10])
    else $error("board busy flag dropped early");
  a_cnt_busy_hold: assert property (status_word[11] && !cnt_cal_done |=> status_word[11])
    else $error("counter busy flag dropped early");
  a_lock_sticky: assert property (status_word[13] |=> status_word[13])
    else $error("locked flag cleared");
  a_cap_on_sticky: assert property (status_word[0] |=> status_word[0])
    else $error("capacity update flag cleared");
  a_locked_refuse: assert property ($past(status_word[13]) && status_word[13] |-> act[4:2] == 3'b000 &&
    !act.full_reset)
    else $error("action while locked");
  a_stretch_len: assert property ($fell(scl_stretch) |-> stretch_len >= STRETCH_CYC &&
    stretch_len <= STRETCH_CYC * 4 / 3 + 1)
    else $error("clock stretch length wrong");
  a_drop_single: assert property (drop_msg |-> msg_start && !xfer_is_i2c)
    else $error("drop outside single-wire start");
  a_wake_clears: assert property (msg_start && osc_off |-> ##[1:40] !status_word[5])
    else $error("deep doze flag not cleared");
  a_act_after_write: assert property (act != '0 |-> hi_hist != '0)
    else $error("action without command word");
endmodule

// ===== verif/host_link_model.sv
// host model issuing byte transactions to the control pair
`timescale 1ns/1ps
module host_link_model (
  input wire logic clk,
  output gauge_ctl_pkg::bus_xfer_s xfer,
  output logic xfer_is_i2c,
  output logic msg_start
);
  // called from the bench process, so every line keeps a single driver
  task init();
    xfer = '0;
    xfer_is_i2c = 1'b1;
    msg_start = 1'b0;
  endtask
  // one byte held a whole cycle from a falling edge
  task put(input logic wr, input logic [7:0] cmd, input logic [7:0] dat);
    xfer = '{1'b1, wr, cmd, dat};
    @(negedge clk);
  endtask
  // released lines show inverted values, never a stale request
  task idle();
    xfer = '{1'b0, ~xfer.write, ~xfer.cmd, ~xfer.data};
  endtask
  task send(input logic [15:0] code);
    put(1'b1, gauge_ctl_pkg::CMD_CTL_LO, code[7:0]);
    put(1'b1, gauge_ctl_pkg::CMD_CTL_HI, code[15:8]);
    idle();
  endtask
  task read_word();
    put(1'b0, gauge_ctl_pkg::CMD_CTL_LO, 8'h00);
    put(1'b0, gauge_ctl_pkg::CMD_CTL_HI, 8'h00);
    idle();
  endtask
  task msg(input logic i2c);
    xfer_is_i2c = i2c;
    msg_start = 1'b1;
    @(negedge clk);
    msg_start = 1'b0;
  endtask
endmodule

// ===== verif/gauge_control_subcommand_unit_tb.sv
// self-checking bench for the control subcommand unit
`timescale 1ns/1ps
module gauge_control_subcommand_unit_tb;
  localparam logic [15:0] DT = 16'h5a3c; // arbitrary value
  localparam logic [15:0] FWR = 16'h0203;
  localparam logic [15:0] HWR = 16'h0011;
  localparam logic [15:0] FLR = 16'h0007;
  localparam logic [15:0] CHM = 16'h0412;
  logic clk = 1'b0;
  logic rst = 1'b1;
  gauge_ctl_pkg::bus_xfer_s xfer;
  gauge_ctl_pkg::gauge_state_s gstate = '0;
  gauge_ctl_pkg::action_s act;
  logic xfer_is_i2c, msg_start, scl_stretch, drop_msg, osc_off;
  logic [15:0] reset_count = '0, current_now = '0, cnt_offset = '0, chem_sum_raw = '0, chem_sum_stored = '0;
  logic board_cal_done = 1'b0, cnt_cal_done = 1'b0, chem_sum_done = 1'b0;
  logic [7:0] rd_byte, learn_progress;
  logic [15:0] status_word, sw, r, exps[8];
  logic [15:0] codes[8] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0005, 16'h0008, 16'h000c, 16'h0018};
  logic [15:0] refused[7] = '{16'h0081, 16'h0041, 16'h0009, 16'h000a, 16'h0010, 16'h0021, 16'h0005};
  logic [4:0] act_seen = '0;
  logic stretch_seen = 1'b0, drop_seen = 1'b0, rd_pend = 1'b0, seen_clr = 1'b0;
  logic [7:0] exp_q[$];
  logic [31:0] rs = 32'd35;
  int err_total = 0, checked = 0, n;
  always #2.5 clk = ~clk;
  gauge_control_subcommand_unit #(.DEVICE_TYPE(DT), .FW_REV(FWR), .HW_REV(HWR), .FLASH_REV(FLR), .CHEMISTRY_ID_QUERY(CHM),
    .STRETCH_CYC(10)) u_dut (.clk(clk), .rst(rst), .xfer(xfer), .xfer_is_i2c(xfer_is_i2c), .msg_start(msg_start),
    .gstate(gstate), .reset_count(reset_count), .current_now(current_now), .cnt_offset(cnt_offset),
    .board_cal_done(board_cal_done), .cnt_cal_done(cnt_cal_done), .chem_sum_done(chem_sum_done),
    .chem_sum_raw(chem_sum_raw), .chem_sum_stored(chem_sum_stored), .rd_byte(rd_byte), .scl_stretch(scl_stretch),
    .drop_msg(drop_msg), .osc_off(osc_off), .learn_progress(learn_progress), .act(act), .status_word(status_word));
  host_link_model u_host (.clk(clk), .xfer(xfer), .xfer_is_i2c(xfer_is_i2c), .msg_start(msg_start));
  // ----
  // helpers
  // ----
  function logic [15:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[15:0];
  endfunction
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task summarize();
    if (err_total == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // answer lands three edges after the high byte
  task cmd(input logic [15:0] c);
    seen_clr = 1'b1;
    u_host.send(c);
    seen_clr = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task expect_word(input logic [15:0] e);
    exp_q.push_back(e[7:0]);
    exp_q.push_back(e[15:8]);
    u_host.read_word();
    repeat (2) @(negedge clk);
  endtask
  task query(input logic [15:0] c, input logic [15:0] e);
    cmd(c);
    expect_word(e);
  endtask
  always @(posedge clk) begin
    rd_pend <= xfer.valid && !xfer.write;
    act_seen <= (seen_clr ? 5'h00 : act_seen) | act;
    stretch_seen <= (seen_clr ? 1'b0 : stretch_seen) | scl_stretch;
    drop_seen <= (seen_clr ? 1'b0 : drop_seen) | drop_msg;
  end
  always @(negedge clk) begin
    if (rd_pend && exp_q.size() > 0) chk(16'(rd_byte), 16'(exp_q.pop_front()));
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    summarize();
  end
  // ----
  // main sequence
  // ----
  initial begin
    u_host.init();
    reset_count = rnd();
    current_now = rnd();
    cnt_offset = rnd();
    repeat (4) @(negedge clk);
    rst = 1'b0;
    chk(status_word, 16'h0000);
    gstate = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    repeat (3) @(negedge clk);
    chk(status_word, 16'h420c);
    gstate = '0;
    exps = '{16'h0000, DT, FWR, HWR, reset_count, CHM, FLR, current_now};
    foreach (codes[i]) query(codes[i], exps[i]);
    query(gauge_ctl_pkg::SC_LAST_SUB, 16'h0018);
    cmd(gauge_ctl_pkg::SC_FULL_RESET);
    chk(16'(act_seen), 16'h0001);
    cmd(gauge_ctl_pkg::SC_GAUGE_START);
    chk(16'({learn_progress[2], status_word[1:0]}), 16'h0007);
    query(gauge_ctl_pkg::SC_LAST_SUB, 16'h0007);
    gstate.volt_bad = 1'b1;
    repeat (3) @(negedge clk);
    chk(16'(status_word[1:0]), 16'h0001);
    gstate.volt_bad = 1'b0;
    for (int i = 0; i < 4; i++) begin
      cmd(i == 0 ? gauge_ctl_pkg::SC_CAL_ENTER : (i == 3 ? gauge_ctl_pkg::SC_CAL_EXIT : gauge_ctl_pkg::SC_CAL_TOGGLE));
      chk(16'(status_word[12]), 16'(i % 2 == 0));
      if (i == 0) query(gauge_ctl_pkg::SC_CAL_OFFSET, cnt_offset);
    end
    // outside cal mode the pair keeps the written code
    query(gauge_ctl_pkg::SC_CAL_OFFSET, gauge_ctl_pkg::SC_CAL_OFFSET);
    for (int i = 0; i < 2; i++) begin
      cmd(i ? gauge_ctl_pkg::SC_CNT_CAL : gauge_ctl_pkg::SC_BOARD_CAL);
      chk(16'(act_seen), i ? 16'h0008 : 16'h0010);
      repeat (6) @(negedge clk);
      chk(16'(status_word[11:10]), i ? 16'h0002 : 16'h0001);
      board_cal_done = (i == 0);
      cnt_cal_done = (i == 1);
      @(negedge clk);
      board_cal_done = 1'b0;
      cnt_cal_done = 1'b0;
      repeat (2) @(negedge clk);
      chk(16'(status_word[11:10]), 16'h0000);
    end
    cmd(gauge_ctl_pkg::SC_CNT_STORE);
    chk(16'(act_seen), 16'h0004);
    for (int j = 0; j < 2; j++) begin
      cmd(gauge_ctl_pkg::SC_CHEM_SUM);
      chk(16'(act_seen), 16'h0002);
      r = rnd();
      chem_sum_raw = r;
      chem_sum_stored = (r & gauge_ctl_pkg::CHKSUM_MASK) ^ 16'(j);
      chem_sum_done = 1'b1;
      @(negedge clk);
      chem_sum_done = 1'b0;
      repeat (3) @(negedge clk);
      expect_word((r & gauge_ctl_pkg::CHKSUM_MASK) | (j ? gauge_ctl_pkg::CHKSUM_FAIL : 16'h0000));
    end
    for (int k = 0; k < 2; k++) begin
      gstate.sleep = 1'b0;
      cmd(gauge_ctl_pkg::SC_ARM_DEEP);
      chk(16'(status_word[5]), 16'h0001);
      gstate.sleep = 1'b1;
      repeat (3) @(negedge clk);
      chk(16'(osc_off), 16'h0001);
      u_host.msg(k == 0);
      n = 0;
      while ((scl_stretch || osc_off) && n < 40) begin
        @(negedge clk);
        n++;
      end
      if (n == 40) begin
        err_total++;
        summarize();
      end
      repeat (2) @(negedge clk);
      chk(16'({stretch_seen, drop_seen}), k ? 16'h0001 : 16'h0002);
      chk(16'(status_word[5:4]), 16'h0001);
    end
    // dropped message is simply sent again
    query(gauge_ctl_pkg::SC_DEV_TYPE, DT);
    gstate.sleep = 1'b0;
    cmd(gauge_ctl_pkg::SC_LOCK);
    chk(16'(status_word[13]), 16'h0001);
    cmd(gauge_ctl_pkg::SC_CHEM_SUM);
    chk(16'(act_seen), 16'h0002);
    sw = status_word;
    foreach (refused[i]) begin
      cmd(refused[i]);
      chk(status_word, sw);
      chk(16'(act_seen), 16'h0000);
    end
    expect_word(gauge_ctl_pkg::SC_RESET_COUNT);
    query(gauge_ctl_pkg::SC_CURRENT, current_now);
    chk(16'(exp_q.size()), 16'h0000);
    summarize();
  end
endmodule
bind gauge_control_subcommand_unit gauge_ctl_sva #(.STRETCH_CYC(STRETCH_CYC)) u_sva (.clk(clk), .rst(rst),
  .xfer(xfer), .xfer_is_i2c(xfer_is_i2c), .msg_start(msg_start), .gstate(gstate),
  .board_cal_done(board_cal_done), .cnt_cal_done(cnt_cal_done), .scl_stretch(scl_stretch),
  .drop_msg(drop_msg), .osc_off(osc_off), .act(act), .status_word(status_word));
